// ### design/awd_pkg.sv
// Shared constants and types for the area wait-state decoder.
// Assumes a single 200 MHz clock domain; no bus, settings arrive as ports.
package awd_pkg;

    localparam int AWD_AREAS  = 4;
    localparam int AWD_CODE_W = 3;
    localparam int AWD_CNT_W  = 5;

    typedef enum logic [2:0] {
        AWD_IF_SRAM  = 3'b000,
        AWD_IF_BROM  = 3'b001,
        AWD_IF_DRAM  = 3'b010,
        AWD_IF_SDRAM = 3'b011,
        AWD_IF_MPX   = 3'b100
    } awd_if_mode_t;

    typedef enum logic [0:0] {
        AWD_ST_IDLE = 1'b0,
        AWD_ST_WAIT = 1'b1
    } awd_state_t;

    typedef logic [AWD_AREAS-1:0][AWD_CODE_W-1:0] awd_code_vec_t;
    typedef awd_if_mode_t [AWD_AREAS-1:0]          awd_mode_vec_t;

    // First-cycle waits per 3-bit code, index 0 is the last element
    localparam logic [7:0][4:0] AWD_FIRST_WAITS =
        {5'h0f, 5'h0c, 5'h09, 5'h06, 5'h03, 5'h02, 5'h01, 5'h00};
    // Column strobe width in cycles per code
    localparam logic [7:0][4:0] AWD_CAS_WIDTH =
        {5'h10, 5'h0d, 5'h0a, 5'h07, 5'h04, 5'h03, 5'h02, 5'h01};
    // Codes with a legal synchronous DRAM latency (1 to 5)
    localparam logic [7:0] AWD_SDRAM_LAT_OK  = 8'h3e;
    // Latency codes 1, 4, 5 clash with row-strobe-held-low mode
    localparam logic [7:0] AWD_RASD_LAT_BAD  = 8'h32;
    localparam logic [4:0] AWD_MPX_MIN_READ  = 5'h01;
    localparam logic [4:0] AWD_GAP_MAX       = 5'h1f;

endpackage

// ### design/awd_dec_if.sv
// Decoded timing of one area, from its decoder to the access sequencer.
// Assumes both ends sit in the same clock domain; values are combinational.
`timescale 1ns/1ps
interface awd_dec_if;
    logic [4:0] first_waits;
    logic [4:0] later_waits;
    logic       first_rdy_en;
    logic       later_rdy_en;
    logic [4:0] cas_width;
    logic [2:0] cas_lat;
    logic       inhibited;

    modport src (output first_waits, later_waits, first_rdy_en, later_rdy_en,
                 output cas_width, cas_lat, inhibited);
    modport dst (input first_waits, later_waits, first_rdy_en, later_rdy_en,
                 input cas_width, cas_lat, inhibited);
endinterface

// ### design/awd_area_decoder.sv
// Decodes one area's 3-bit wait code under the area's interface mode.
// Assumes codes and modes are quasi-static; output is purely combinational.
`timescale 1ns/1ps
module awd_area_decoder #(
    parameter int AREA = 0
) (
    input  wire logic [2:0]           i_code,
    input  wire logic [2:0]           i_pitch,
    input  wire awd_pkg::awd_if_mode_t i_mode,
    input  wire logic                 i_write,
    input  wire logic                 i_ras_down,
    awd_dec_if.src                    dec
);
    import awd_pkg::*;

    always_comb begin
        dec.first_waits  = AWD_FIRST_WAITS[i_code];
        dec.later_waits  = AWD_FIRST_WAITS[i_code];
        dec.first_rdy_en = (i_code != 3'h0);
        dec.later_rdy_en = (i_code != 3'h0);
        dec.cas_width    = AWD_CAS_WIDTH[i_code];
        dec.cas_lat      = i_code;
        dec.inhibited    = 1'b0;
        case (i_mode)
            AWD_IF_BROM: begin
                // Burst ROM exists on area 0 only; elsewhere it acts as SRAM
                if (AREA == 0) begin
                    dec.later_waits  = {2'h0, i_pitch};
                    dec.later_rdy_en = (i_pitch != 3'h0);
                end
            end
            AWD_IF_DRAM: begin
                if (AREA >= 2) begin
                    // Beat cycle is the last strobe cycle
                    dec.first_waits  = AWD_CAS_WIDTH[i_code] - 5'h01;
                    dec.later_waits  = AWD_CAS_WIDTH[i_code] - 5'h01;
                    dec.first_rdy_en = 1'b0;
                    dec.later_rdy_en = 1'b0;
                end
            end
            AWD_IF_SDRAM: begin
                if (AREA >= 2) begin
                    dec.first_waits  = {2'h0, i_code};
                    dec.later_waits  = 5'h00;
                    dec.first_rdy_en = 1'b0;
                    dec.later_rdy_en = 1'b0;
                    // Flags software slips, does not correct them
                    dec.inhibited    = !AWD_SDRAM_LAT_OK[i_code]
                                       || (i_ras_down && AWD_RASD_LAT_BAD[i_code]);
                end
            end
            AWD_IF_MPX: begin
                if (i_write) begin
                    dec.first_waits = {3'h0, i_code[1:0]};
                end else if (i_code[1:0] == 2'h0) begin
                    dec.first_waits = AWD_MPX_MIN_READ;
                end else begin
                    dec.first_waits = {3'h0, i_code[1:0]};
                end
                dec.later_waits  = {4'h0, i_code[2]};
                dec.first_rdy_en = 1'b1;
                dec.later_rdy_en = 1'b1;
            end
            default: begin
            end
        endcase
    end

endmodule

// ### design/awd_wait_sequencer.sv
// Top of the area wait-state decoder: decodes areas 0..3 and paces accesses.
// Assumes settings are plain ports held stable while o_busy is high and the
// ready pin is asynchronous to i_ref_clk.
`timescale 1ns/1ps

// Behaviour
// - Area 3/2 SRAM codes 0..7 give 0,1,2,3,6,9,12,15 first waits.
// - SRAM code zero ignores ready, nonzero honours it; multiplexed honours it for every code.
// - Area 2/3 DRAM or synchronous DRAM always ignores the ready input.
// - Area 2/3 DRAM column strobe lasts 1,2,3,4,7,10,13,16 cycles.
// - Area 2/3 synchronous DRAM latency equals codes 1 through 5.
// - Area 0 burst ROM inserts pitch-code waits before each later beat.
// - Pitch zero ignores ready on later beats; nonzero honours it.
// - Multiplexed: low bits give write waits 0..3, read 1,1,2,3; ready honoured.
// - Multiplexed: top code bit gives 0 or 1 waits on later beats.
module awd_wait_sequencer #(
    parameter int BEAT_W = 2
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_srst,
    input  wire logic [2:0]            i_area3_wait_code,
    input  wire logic [2:0]            i_area2_wait_code,
    input  wire logic [2:0]            i_area1_wait_code,
    input  wire logic [2:0]            i_area0_wait_code,
    input  wire logic [2:0]            i_area0_burst_pitch_code,
    input  wire awd_pkg::awd_mode_vec_t i_area_mode,
    input  wire logic                  i_ras_down,
    input  wire logic                  i_access_start,
    input  wire logic [1:0]            i_access_area,
    input  wire logic                  i_access_write,
    input  wire logic [BEAT_W-1:0]     i_access_beats,
    input  wire logic                  i_ext_ready_n,
    output logic                       o_busy,
    output logic                       o_beat,
    output logic                       o_done,
    output logic                       o_cas_strobe,
    output logic [2:0]                 o_cas_latency,
    output logic                       o_cfg_inhibited
);
    import awd_pkg::*;

    awd_code_vec_t      codes;
    awd_dec_if          dec[AWD_AREAS]();
    logic [4:0]         first_w   [AWD_AREAS];
    logic [4:0]         later_w   [AWD_AREAS];
    logic               first_rdy [AWD_AREAS];
    logic               later_rdy [AWD_AREAS];
    logic [4:0]         cas_w     [AWD_AREAS];
    logic [2:0]         cas_l     [AWD_AREAS];

    awd_state_t         state;
    logic [4:0]         cnt;
    logic [4:0]         cur_waits;
    logic [4:0]         cur_later;
    logic               cur_rdy;
    logic               cur_later_rdy;
    logic [4:0]         cur_cas;
    awd_if_mode_t       cur_mode;
    logic [BEAT_W-1:0]  beats_left;
    logic               rdy_ff1;
    logic               rdy_ff2;
    logic               rdy_ff3;
    logic               rdy_wait;
    logic [4:0]         gap;
    logic               start_ok;

    assign codes = {i_area3_wait_code, i_area2_wait_code,
                    i_area1_wait_code, i_area0_wait_code};

    for (genvar g = 0; g < AWD_AREAS; g++) begin : g_area
        awd_area_decoder #(
            .AREA       (g)
        ) u_dec (
            .i_code     (codes[g]),
            .i_pitch    (i_area0_burst_pitch_code),
            .i_mode     (i_area_mode[g]),
            .i_write    (i_access_write),
            .i_ras_down (i_ras_down),
            .dec        (dec[g])
        );
        assign first_w[g]   = dec[g].first_waits;
        assign later_w[g]   = dec[g].later_waits;
        assign first_rdy[g] = dec[g].first_rdy_en;
        assign later_rdy[g] = dec[g].later_rdy_en;
        assign cas_w[g]     = dec[g].cas_width;
        assign cas_l[g]     = dec[g].cas_lat;
    end

    // Pin is asynchronous; a change counts once two stages agree
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rdy_ff1  <= 1'b0;
            rdy_ff2  <= 1'b0;
            rdy_ff3  <= 1'b0;
            rdy_wait <= 1'b0;
        end else begin
            rdy_ff1 <= i_ext_ready_n;
            rdy_ff2 <= rdy_ff1;
            rdy_ff3 <= rdy_ff2;
            if (rdy_ff2 == rdy_ff3) begin
                rdy_wait <= rdy_ff3;
            end
        end
    end

    assign start_ok     = i_access_start && (state == AWD_ST_IDLE);
    assign o_busy       = (state == AWD_ST_WAIT);
    assign o_beat       = o_busy && (cnt == 5'h00) && !(cur_rdy && rdy_wait);
    assign o_done       = o_beat && (beats_left == '0);
    assign o_cas_strobe = o_busy && (cur_mode == AWD_IF_DRAM);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state         <= AWD_ST_IDLE;
            cnt           <= 5'h00;
            cur_waits     <= 5'h00;
            cur_later     <= 5'h00;
            cur_rdy       <= 1'b0;
            cur_later_rdy <= 1'b0;
            cur_cas       <= 5'h00;
            cur_mode      <= AWD_IF_SRAM;
            beats_left    <= '0;
        end else begin
            case (state)
                AWD_ST_IDLE: begin
                    if (start_ok) begin
                        state         <= AWD_ST_WAIT;
                        cnt           <= first_w[i_access_area];
                        cur_waits     <= first_w[i_access_area];
                        cur_later     <= later_w[i_access_area];
                        cur_rdy       <= first_rdy[i_access_area];
                        cur_later_rdy <= later_rdy[i_access_area];
                        cur_cas       <= cas_w[i_access_area];
                        cur_mode      <= i_area_mode[i_access_area];
                        beats_left    <= i_access_beats;
                    end
                end
                AWD_ST_WAIT: begin
                    if (cnt != 5'h00) begin
                        cnt <= cnt - 5'h01;
                    end else if (o_done) begin
                        state <= AWD_ST_IDLE;
                    end else if (o_beat) begin
                        beats_left <= beats_left - 1'b1;
                        cnt        <= cur_later;
                        cur_waits  <= cur_later;
                        cur_rdy    <= cur_later_rdy;
                    end
                end
                default: begin
                    state <= AWD_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_cas_latency <= 3'h0;
        end else if (start_ok && i_access_area[1]
                     && i_area_mode[i_access_area] == AWD_IF_SDRAM) begin
            // Areas 0 and 1 fall back to SRAM timing, so no latency there
            o_cas_latency <= cas_l[i_access_area];
        end
    end

    // Only areas 2 and 3 can carry synchronous DRAM
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_cfg_inhibited <= 1'b0;
        end else begin
            o_cfg_inhibited <= dec[2].inhibited || dec[3].inhibited;
        end
    end

    // Cycles since start or last beat, saturating for long ready stalls
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || start_ok || o_beat) begin
            gap <= 5'h00;
        end else if (o_busy && gap != AWD_GAP_MAX) begin
            gap <= gap + 5'h01;
        end
    end

    chk_gap_exact: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        o_beat && !cur_rdy |-> gap == cur_waits)
        else $error("beat spacing differs from programmed waits");

    chk_gap_min: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        o_beat |-> gap >= cur_waits)
        else $error("beat came before programmed waits elapsed");

    chk_rdy_stretch: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        o_busy && cnt == 5'h00 && cur_rdy && rdy_wait |-> !o_beat ##1 o_busy)
        else $error("ready stall not honoured");

    chk_zero_code_rdy: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        i_area0_wait_code == 3'h0 && i_area_mode[0] == AWD_IF_SRAM
        |-> !dec[0].first_rdy_en && dec[0].first_waits == 5'h00)
        else $error("zero code must ignore ready");

    chk_dram_no_rdy: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        start_ok && (i_area_mode[i_access_area] inside {AWD_IF_DRAM, AWD_IF_SDRAM})
        && i_access_area[1] |=> !cur_rdy)
        else $error("dram access honours ready");

    chk_cas_width: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        o_beat && cur_mode == AWD_IF_DRAM |-> o_cas_strobe && gap + 5'h01 == cur_cas)
        else $error("column strobe width wrong");

    chk_sdram_latency: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        start_ok && i_area_mode[i_access_area] == AWD_IF_SDRAM && i_access_area[1]
        |=> o_cas_latency == $past(codes[i_access_area]) && cnt == {2'h0, o_cas_latency})
        else $error("latency not taken from code");

    chk_mpx_read: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        i_area_mode[1] == AWD_IF_MPX && !i_access_write && i_area1_wait_code[1:0] == 2'h0
        |-> dec[1].first_waits == 5'h01 && dec[1].first_rdy_en)
        else $error("multiplexed read wait wrong");

    chk_mpx_later: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        i_area_mode[2] == AWD_IF_MPX |-> dec[2].later_waits == {4'h0, i_area2_wait_code[2]})
        else $error("multiplexed later wait wrong");

    chk_pitch_rdy: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        i_area_mode[0] == AWD_IF_BROM |-> dec[0].later_rdy_en == (i_area0_burst_pitch_code != 3'h0)
        && dec[0].later_waits == {2'h0, i_area0_burst_pitch_code})
        else $error("burst pitch decode wrong");

    chk_sdram_inhibit: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        i_area_mode[3] == AWD_IF_SDRAM && i_area3_wait_code == 3'h6 |=> o_cfg_inhibited)
        else $error("inhibited latency not flagged");

endmodule

// ### bench/awd_ext_device.sv
// Far-side memory device model: pulls the ready pin into wait on command.
// Assumes the bench raises i_stall before an access; the pin is push-pull.
`timescale 1ns/1ps
module awd_ext_device (
    input  wire logic       i_ref_clk,
    input  wire logic       i_srst,
    input  wire logic       i_busy,
    input  wire logic       i_stall,
    input  wire logic [4:0] i_len,
    output logic            o_ext_ready_n
);
    logic [4:0] held;

    // Counts busy cycles so the wait ends a fixed span into the access
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || !i_stall) begin
            held <= 5'h00;
        end else if (i_busy && held != i_len) begin
            held <= held + 5'h01;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        o_ext_ready_n <= !i_srst && i_stall && (held != i_len);
    end
endmodule

// ### bench/awd_wait_sequencer_test.sv
// Self-checking bench for the area wait-state decoder top.
// Assumes a 200 MHz clock; measures beat timing in cycles from the take.
`timescale 1ns/1ps
module awd_wait_sequencer_test;
    import awd_pkg::*;
    logic            clk, srst, start, wr, ras_down, stall, rdy_n;
    logic [3:0][2:0] wc;
    logic [2:0]      pitch, lat;
    awd_mode_vec_t   mode;
    logic [1:0]      area, beats;
    logic [4:0]      slen;
    logic            busy, beat, done, strobe, inh;
    int              err_total, n_compared, n1, n2, nstr;
    int              tw[8] = '{0, 1, 2, 3, 6, 9, 12, 15};
    int              cw[8] = '{1, 2, 3, 4, 7, 10, 13, 16};
    int              mr[4] = '{1, 1, 2, 3};

    awd_wait_sequencer #(.BEAT_W(2)) uut (
        .i_ref_clk(clk), .i_srst(srst), .i_area3_wait_code(wc[3]),
        .i_area2_wait_code(wc[2]), .i_area1_wait_code(wc[1]),
        .i_area0_wait_code(wc[0]), .i_area0_burst_pitch_code(pitch),
        .i_area_mode(mode), .i_ras_down(ras_down), .i_access_start(start),
        .i_access_area(area), .i_access_write(wr), .i_access_beats(beats),
        .i_ext_ready_n(rdy_n), .o_busy(busy), .o_beat(beat), .o_done(done),
        .o_cas_strobe(strobe), .o_cas_latency(lat), .o_cfg_inhibited(inh));

    awd_ext_device partner (.i_ref_clk(clk), .i_srst(srst), .i_busy(busy),
        .i_stall(stall), .i_len(slen), .o_ext_ready_n(rdy_n));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check_vec(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Counts are bench values; min mode accepts any longer stretch
    task automatic check_cnt(input int got, input int exp, input bit exact);
        n_compared++;
        if (exact ? got != exp : got < exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic cfg(input int a, input awd_if_mode_t m, input int c);
        @(posedge clk);
        mode[a] <= m;
        wc[a]   <= 3'(c);
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic run(input int a, input bit w, input int b, input int e1,
                       input int e2, input bit exact);
        int n;
        int nb;
        n = 0;
        nb = 0;
        n1 = 0;
        n2 = 0;
        nstr = 0;
        @(posedge clk);
        area  <= 2'(a);
        wr    <= w;
        beats <= 2'(b);
        start <= 1'b1;
        while (nb <= b && n < 80) begin
            @(posedge clk);
            start <= 1'b0;
            n++;
            #1;
            if (strobe === 1'b1) nstr++;
            if (beat === 1'b1) begin
                if (nb == 0) n1 = n;
                else n2 = n - n1;
                nb++;
                check_vec({7'h00, done}, 8'(nb > b));
            end
        end
        // A cut-off loop shows up here as a missing beat
        check_cnt(nb, b + 1, 1);
        check_cnt(n1, e1, exact);
        if (b != 0) check_cnt(n2, e2, exact);
        @(posedge clk);
        #1;
        check_vec({7'h00, busy}, 8'h00);
    endtask

    task automatic stalled(input int a, input bit w, input int b, input int e1,
                           input int e2, input bit exact);
        @(posedge clk);
        slen  <= 5'h0a;
        stall <= 1'b1;
        repeat (6) @(posedge clk);
        run(a, w, b, e1, e2, exact);
        @(posedge clk);
        stall <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end

    initial begin
        err_total  = 0;
        n_compared = 0;
        srst       = 1'b1;
        start      = 1'b0;
        wr         = 1'b0;
        ras_down   = 1'b0;
        stall      = 1'b0;
        wc         = '0;
        pitch      = 3'h0;
        area       = 2'h0;
        beats      = 2'h0;
        slen       = 5'h00;
        mode = '{default: AWD_IF_SRAM};
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check_vec({6'h00, busy, inh}, 8'h00);
        for (int a = 0; a < 4; a++) begin
            for (int c = 0; c < 8; c++) begin
                cfg(a, AWD_IF_SRAM, c);
                run(a, 0, 1, tw[c] + 1, tw[c] + 1, 1);
                check_cnt(nstr, 0, 1);
            end
        end
        for (int a = 2; a < 4; a++) begin
            for (int c = 0; c < 8; c++) begin
                cfg(a, AWD_IF_DRAM, c);
                run(a, 0, 0, cw[c], 0, 1);
                check_cnt(nstr, cw[c], 1);
                cfg(a, AWD_IF_SDRAM, c);
                check_vec({7'h00, inh}, 8'(c == 0 || c > 5));
                if (c >= 1 && c <= 5) begin
                    run(a, 0, 0, c + 1, 0, 1);
                    check_vec({5'h00, lat}, 8'(c));
                end
            end
            @(posedge clk);
            ras_down <= 1'b1;
            for (int c = 1; c < 6; c++) begin
                cfg(a, AWD_IF_SDRAM, c);
                check_vec({7'h00, inh}, 8'(c != 2 && c != 3));
            end
            @(posedge clk);
            ras_down <= 1'b0;
            cfg(a, AWD_IF_SRAM, 0);
        end
        for (int p = 0; p < 8; p++) begin
            @(posedge clk);
            pitch <= 3'(p);
            cfg(0, AWD_IF_BROM, 2);
            run(0, 0, 1, 3, p + 1, 1);
        end
        for (int a = 0; a < 4; a++) begin
            for (int c = 0; c < 8; c++) begin
                cfg(a, AWD_IF_MPX, c);
                run(a, 0, 1, mr[c % 4] + 1, c / 4 + 1, 1);
                run(a, 1, 1, c % 4 + 1, c / 4 + 1, 1);
            end
        end
        cfg(1, AWD_IF_SRAM, 1);
        stalled(1, 0, 0, 11, 0, 0);
        cfg(1, AWD_IF_SRAM, 0);
        stalled(1, 0, 0, 1, 0, 1);
        cfg(2, AWD_IF_DRAM, 2);
        stalled(2, 0, 0, 3, 0, 1);
        cfg(3, AWD_IF_SDRAM, 3);
        stalled(3, 0, 0, 4, 0, 1);
        cfg(1, AWD_IF_MPX, 0);
        stalled(1, 1, 0, 11, 0, 0);
        pitch <= 3'h0;
        cfg(0, AWD_IF_BROM, 0);
        stalled(0, 0, 1, 1, 1, 1);
        pitch <= 3'h3;
        cfg(0, AWD_IF_BROM, 0);
        stalled(0, 0, 1, 1, 10, 0);
        complete_run();
    end
endmodule
